// ---- timer0_ctrl_pkg.sv ----
`default_nettype none
package timer0_ctrl_pkg;
  // ----------------------------------------
  // Register offsets in the I/O space
  // ----------------------------------------
  localparam logic [5:0] CNT_HIGH_ADDR = 6'h14;
  localparam logic [5:0] CTRL_A_ADDR = 6'h15;
  localparam logic [5:0] CNT_LOW_ADDR = 6'h32;
  localparam logic [5:0] CTRL_B_ADDR = 6'h33;
  // ----------------------------------------
  // Control A field positions
  // ----------------------------------------
  localparam int A_WIDTH_BIT = 7;
  localparam int A_CAP_EN_BIT = 6;
  localparam int A_FILT_BIT = 5;
  localparam int A_EDGE_BIT = 4;
  localparam int A_COMP_BIT = 3;
  localparam int A_CTC_BIT = 0;
  // ----------------------------------------
  // Control B field positions
  // ----------------------------------------
  localparam int B_SYNC_BIT = 4;
  localparam int B_PSR_BIT = 3;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  // ----------------------------------------
  // Clock select codes
  // ----------------------------------------
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  // ----------------------------------------
  // Timing counts
  // ----------------------------------------
  localparam int FILTER_SAMPLES = 4;
  localparam int PRESCALE_BITS = 10;
endpackage : timer0_ctrl_pkg
`default_nettype wire

// ---- timer0_capture_prescale_ctrl.sv ----
// Operation
// - Capture enable bit selects input capture operation
// - Filter output changes after four equal samples
// - Filter delays capture event by four cycles
// - Edge select: zero falling, one rising
// - Capture copies counter and sets capture flag
// - Comparator feeds capture path when selected
// - Control A bits 2:1 read zero
// - Mode bit picks normal or clear-on-match
// - Sync mode keeps prescaler reset bit held
// - Clearing sync mode clears prescaler reset
// - Prescaler reset bit self-clears outside sync mode
// - Clock select: stop, div 1/8/64/256/1024
// - Codes 110/111 count external falling/rising edges
// - External pin counts even when driven locally
// - Low byte gives direct counter access
// - Low byte write blocks next tick's match pulse; clear-on-match still clears
// - 16-bit mode: low and high counter bytes
// - Shared temporary high byte for 16-bit access
// - Width bit selects 16-bit operation
// - Low write loads both bytes; low read latches
// - Capture flag cleared by vector or one
`timescale 1ns/1ns
`default_nettype none
module timer0_capture_prescale_ctrl (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [5:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  output logic [7:0] io_rdata_o,
  input wire logic capture_input_pin_i,
  input wire logic comparator_out_i,
  input wire logic external_count_pin_i,
  input wire logic [15:0] compare_value_i,
  input wire logic capture_flag_clear_i,
  input wire logic capture_vector_ack_i,
  output logic capture_flag_o,
  output logic [15:0] capture_value_o,
  output logic compare_match_o,
  output logic [15:0] counter_o,
  output logic [7:0] temp_o
);
  import timer0_ctrl_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic width_select_16bit_r, capture_mode_enable_r, capture_noise_filter_enable_r;
  logic capture_edge_select_r, comparator_capture_select_r, clear_on_match_mode_r;
  logic sync_hold_mode_r, prescaler_reset_r;
  logic [2:0] clock_select_field_r;
  logic [15:0] cnt_r;
  logic [7:0] temp_r;
  logic [7:0] rdata_r;
  logic [15:0] cap_r;
  logic flag_r, match_r, block_r;
  logic cap_s1_r, cap_s2_r, cmp_s1_r, cmp_s2_r, ext_s1_r, ext_s2_r, ext_d_r;
  logic [FILTER_SAMPLES-1:0] hist_r;
  logic filt_r, prev_r;
  logic [PRESCALE_BITS-1:0] pre_r;
  logic src, lvl, rise, fall, trig, ext_rise, ext_fall, tick, cmp_hit;
  logic wr_a, wr_b, wr_lo, wr_hi, rd_lo;
  logic [FILTER_SAMPLES-1:0] win;

  // Strobe decode for the four registers
  assign wr_a = io_wr_i && (io_addr_i == CTRL_A_ADDR);
  assign wr_b = io_wr_i && (io_addr_i == CTRL_B_ADDR);
  assign wr_lo = io_wr_i && (io_addr_i == CNT_LOW_ADDR);
  assign wr_hi = io_wr_i && (io_addr_i == CNT_HIGH_ADDR);
  assign rd_lo = io_rd_i && (io_addr_i == CNT_LOW_ADDR);

  // ----------------------------------------
  // Tick decode
  // ----------------------------------------
  // All-ones low bits of the free prescaler mark one divided period
  function automatic logic tick_of(input logic [2:0] cs, input logic [PRESCALE_BITS-1:0] p,
                                   input logic er, input logic ef);
    logic t;
    t = 1'b0;
    case (cs)
      CS_STOP: t = 1'b0;
      CS_DIV1: t = 1'b1;
      CS_DIV8: t = &p[2:0];
      CS_DIV64: t = &p[5:0];
      CS_DIV256: t = &p[7:0];
      CS_DIV1024: t = &p[9:0];
      CS_EXT_FALL: t = ef;
      default: t = er;
    endcase
    return t;
  endfunction : tick_of

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Two flops per pin; the pin's own direction is irrelevant here
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      {cap_s1_r, cap_s2_r, cmp_s1_r, cmp_s2_r} <= 4'h0;
      {ext_s1_r, ext_s2_r, ext_d_r} <= 3'h0;
    end else if (ce_i) begin
      cap_s1_r <= capture_input_pin_i;
      cap_s2_r <= cap_s1_r;
      cmp_s1_r <= comparator_out_i;
      cmp_s2_r <= cmp_s1_r;
      ext_s1_r <= external_count_pin_i;
      ext_s2_r <= ext_s1_r;
      ext_d_r <= ext_s2_r;
    end
  end

  // Edge detection on the synchronised count pin
  assign ext_rise = ext_s2_r && !ext_d_r;
  assign ext_fall = !ext_s2_r && ext_d_r;

  // ----------------------------------------
  // Capture front end
  // ----------------------------------------
  // Comparator is cut off entirely unless selected
  assign src = comparator_capture_select_r ? cmp_s2_r : cap_s2_r;
  assign win = {hist_r[FILTER_SAMPLES-2:0], src};

  // Filter: history of samples, output moves only on a full agreeing window
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      hist_r <= '0;
      filt_r <= 1'b0;
    end else if (ce_i) begin
      hist_r <= win;
      if (&win) begin
        filt_r <= 1'b1;
      end else if (~|win) begin
        filt_r <= 1'b0;
      end
    end
  end

  // Filtered path lags the raw one by the window length
  assign lvl = capture_noise_filter_enable_r ? filt_r : src;
  assign rise = lvl && !prev_r;
  assign fall = !lvl && prev_r;
  assign trig = capture_mode_enable_r && (capture_edge_select_r ? rise : fall);

  // Previous level for edge detection
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      prev_r <= 1'b0;
    end else if (ce_i) begin
      prev_r <= lvl;
    end
  end

  // Capture register and flag; a new event wins over a clear
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cap_r <= CNT_RESET;
      flag_r <= 1'b0;
    end else if (ce_i) begin
      if (trig) begin
        cap_r <= width_select_16bit_r ? cnt_r : {8'h00, cnt_r[7:0]};
        flag_r <= 1'b1;
      end else if (capture_flag_clear_i || capture_vector_ack_i) begin
        flag_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Control A plain fields
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      {width_select_16bit_r, capture_mode_enable_r, capture_noise_filter_enable_r} <= CTRL_A_RESET[7:5];
      {capture_edge_select_r, comparator_capture_select_r} <= CTRL_A_RESET[4:3];
      clear_on_match_mode_r <= CTRL_A_RESET[0];
    end else if (ce_i && wr_a) begin
      width_select_16bit_r <= io_wdata_i[A_WIDTH_BIT];
      capture_mode_enable_r <= io_wdata_i[A_CAP_EN_BIT];
      capture_noise_filter_enable_r <= io_wdata_i[A_FILT_BIT];
      capture_edge_select_r <= io_wdata_i[A_EDGE_BIT];
      comparator_capture_select_r <= io_wdata_i[A_COMP_BIT];
      clear_on_match_mode_r <= io_wdata_i[A_CTC_BIT];
    end
  end

  // Control B; the reset bit is held only while sync mode is on
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      sync_hold_mode_r <= CTRL_B_RESET[B_SYNC_BIT];
      prescaler_reset_r <= CTRL_B_RESET[B_PSR_BIT];
      clock_select_field_r <= CTRL_B_RESET[2:0];
    end else if (ce_i) begin
      if (wr_b) begin
        sync_hold_mode_r <= io_wdata_i[B_SYNC_BIT];
        prescaler_reset_r <= io_wdata_i[B_PSR_BIT];
        clock_select_field_r <= io_wdata_i[2:0];
      end else if (!sync_hold_mode_r) begin
        prescaler_reset_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Prescaler and counter
  // ----------------------------------------
  // Free divider, held at zero while its reset bit is set
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      pre_r <= '0;
    end else if (ce_i) begin
      if (prescaler_reset_r) begin
        pre_r <= '0;
      end else begin
        pre_r <= pre_r + 1'b1;
      end
    end
  end

  // Reset bit also blocks undivided and pin ticks so nothing advances
  assign tick = !prescaler_reset_r &&
    tick_of(clock_select_field_r, pre_r, ext_rise, ext_fall);
  assign cmp_hit = width_select_16bit_r ? (cnt_r == compare_value_i) :
                   (cnt_r[7:0] == compare_value_i[7:0]);

  // Counter: CPU write beats match clear, which beats the count tick
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cnt_r <= CNT_RESET;
    end else if (ce_i) begin
      if (wr_lo) begin
        if (width_select_16bit_r) begin
          cnt_r <= {temp_r, io_wdata_i};
        end else begin
          cnt_r[7:0] <= io_wdata_i;
        end
      end else if (wr_hi && !width_select_16bit_r) begin
        cnt_r[15:8] <= io_wdata_i;
      end else if (tick && cmp_hit && clear_on_match_mode_r && !capture_mode_enable_r) begin
        cnt_r <= CNT_RESET;
      end else if (tick) begin
        if (width_select_16bit_r) begin
          cnt_r <= cnt_r + 16'h0001;
        end else begin
          cnt_r[7:0] <= cnt_r[7:0] + 8'h01;
        end
      end
    end
  end

  // Match pulse, suppressed for the first tick after a low-byte write
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      block_r <= 1'b0;
      match_r <= 1'b0;
    end else if (ce_i) begin
      if (wr_lo) begin
        block_r <= 1'b1;
      end else if (tick) begin
        block_r <= 1'b0;
      end
      match_r <= tick && cmp_hit && !block_r && !wr_lo && !capture_mode_enable_r;
    end
  end

  // ----------------------------------------
  // Temporary latch and read data
  // ----------------------------------------
  // One latch shared by every 16-bit access so bytes move together
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      temp_r <= 8'h00;
    end else if (ce_i && width_select_16bit_r) begin
      if (wr_hi) begin
        temp_r <= io_wdata_i;
      end else if (rd_lo) begin
        temp_r <= cnt_r[15:8];
      end
    end
  end

  // Registered read data, one cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rdata_r <= 8'h00;
    end else if (ce_i) begin
      if (!io_rd_i) begin
        rdata_r <= 8'h00;
      end else if (io_addr_i == CTRL_A_ADDR) begin
        rdata_r <= {width_select_16bit_r, capture_mode_enable_r, capture_noise_filter_enable_r,
                    capture_edge_select_r, comparator_capture_select_r, 2'b00,
                    clear_on_match_mode_r};
      end else if (io_addr_i == CTRL_B_ADDR) begin
        rdata_r <= {3'b000, sync_hold_mode_r, prescaler_reset_r, clock_select_field_r};
      end else if (io_addr_i == CNT_LOW_ADDR) begin
        rdata_r <= cnt_r[7:0];
      end else if (io_addr_i == CNT_HIGH_ADDR) begin
        rdata_r <= width_select_16bit_r ? temp_r : cnt_r[15:8];
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end

  // Outputs straight from flops
  assign io_rdata_o = rdata_r;
  assign capture_flag_o = flag_r;
  assign capture_value_o = cap_r;
  assign compare_match_o = match_r;
  assign counter_o = cnt_r;
  assign temp_o = temp_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i || !ce_i);

  filter_window_a: assert property ((capture_noise_filter_enable_r && filt_r != $past(filt_r)) |->
    (hist_r == {FILTER_SAMPLES{filt_r}})) else $error("filter moved without agreement");
  capture_copy_a: assert property (trig |=> (flag_r && cap_r[7:0] == $past(cnt_r[7:0])))
    else $error("capture did not copy counter");
  // Checked against the synced pin itself, not against the edge detector it guards
  edge_select_a: assert property ((trig && !capture_noise_filter_enable_r &&
    !comparator_capture_select_r && $past(!capture_noise_filter_enable_r && !comparator_capture_select_r)) |->
    (cap_s2_r == capture_edge_select_r && $past(cap_s2_r) != capture_edge_select_r))
    else $error("capture on wrong edge");
  reserved_zero_a: assert property ((io_rd_i && io_addr_i == CTRL_A_ADDR) |=>
    (io_rdata_o[2:1] == 2'b00)) else $error("reserved bits not zero");
  psr_autoclear_a: assert property ((prescaler_reset_r && !sync_hold_mode_r && !wr_b) |=>
    !prescaler_reset_r) else $error("prescaler reset stuck");
  psr_hold_a: assert property ((prescaler_reset_r && sync_hold_mode_r && !wr_b) |=>
    ((prescaler_reset_r && $stable(cnt_r)) || $past(wr_lo || wr_hi))) else $error("held counter moved");
  stop_mode_a: assert property ((clock_select_field_r == CS_STOP && !io_wr_i) |=> $stable(cnt_r))
    else $error("stopped counter moved");
  low_write_a: assert property ((wr_lo && width_select_16bit_r) |=>
    (cnt_r == {$past(temp_r), $past(io_wdata_i)})) else $error("16-bit write wrong");
  match_block_a: assert property (wr_lo |=> (!match_r ##1 !(match_r && $past(tick)) [*1]))
    else $error("match not blocked");
  ext_tick_a: assert property ((clock_select_field_r == CS_EXT_RISE && !prescaler_reset_r) |->
    (tick == ext_rise)) else $error("external tick wrong");

  capture_seen_c: cover property (trig ##1 flag_r);
  filtered_capture_c: cover property (capture_noise_filter_enable_r && trig);
  ctc_clear_c: cover property (tick && cmp_hit && clear_on_match_mode_r ##1 cnt_r == CNT_RESET);
  sync_release_c: cover property (sync_hold_mode_r && prescaler_reset_r ##1 !prescaler_reset_r);
endmodule : timer0_capture_prescale_ctrl
`default_nettype wire

// ---- cpu_bus_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// CPU side of the 8-bit register bus
// ----------------------------------------
module cpu_bus_model (
  input wire logic clk_sys_i,
  input wire logic [7:0] io_rdata_i,
  output logic [5:0] io_addr_o,
  output logic [7:0] io_wdata_o,
  output logic io_wr_o,
  output logic io_rd_o
);
  import timer0_ctrl_pkg::*;
  // Bus idle from time zero
  initial begin
    io_addr_o = 6'h00;
    io_wdata_o = 8'h00;
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
  end
  // One write strobe; data is scrambled after so stale data is never trusted
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    io_addr_o <= a;
    io_wdata_o <= d;
    io_wr_o <= 1'b1;
    @(posedge clk_sys_i);
    io_wr_o <= 1'b0;
    io_wdata_o <= ~d;
    #1;
  endtask : wr
  // One read strobe; read data stands only in the cycle after it is taken
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    io_addr_o <= a;
    io_rd_o <= 1'b1;
    @(posedge clk_sys_i);
    io_rd_o <= 1'b0;
    #1;
    d = io_rdata_i;
  endtask : rd
  // High byte goes first, so the low write moves both bytes at once
  task automatic wr16(input logic [15:0] v);
    wr(CNT_HIGH_ADDR, v[15:8]);
    wr(CNT_LOW_ADDR, v[7:0]);
  endtask : wr16
endmodule : cpu_bus_model
`default_nettype wire

// ---- tb_timer0_capture_prescale_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_timer0_capture_prescale_ctrl;
  import timer0_ctrl_pkg::*;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic cap_pin = 1'b0, cmp_pin = 1'b0, ext_pin = 1'b0, flag_clr = 1'b0, vec_ack = 1'b0;
  logic [15:0] cmp_val = 16'h0040;
  logic [5:0] addr;
  logic [7:0] wdata, rdata, temp;
  logic wr, rd, cap_flag, match;
  logic [15:0] cap_val, cnt;
  logic [31:0] seed = 32'h00000026;
  int fail_count = 0;
  int tests_run = 0;
  // ----------------------------------------
  // Clock, bus partner and design
  // ----------------------------------------
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  cpu_bus_model cpu_u (.clk_sys_i(clk_sys_i), .io_rdata_i(rdata), .io_addr_o(addr),
    .io_wdata_o(wdata), .io_wr_o(wr), .io_rd_o(rd));
  timer0_capture_prescale_ctrl dut_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(1'b1),
    .io_addr_i(addr), .io_wdata_i(wdata), .io_wr_i(wr), .io_rd_i(rd), .io_rdata_o(rdata),
    .capture_input_pin_i(cap_pin), .comparator_out_i(cmp_pin), .external_count_pin_i(ext_pin),
    .compare_value_i(cmp_val), .capture_flag_clear_i(flag_clr), .capture_vector_ack_i(vec_ack),
    .capture_flag_o(cap_flag), .capture_value_o(cap_val), .compare_match_o(match),
    .counter_o(cnt), .temp_o(temp));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : cyc
  task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] v;
    cpu_u.rd(a, v);
    check({8'h00, v}, {8'h00, exp});
  endtask : rchk
  // Move one capture source, then count cycles to the flag (20 means none)
  task automatic edge_on(input logic from_cmp, input logic lvl, output int n);
    @(posedge clk_sys_i);
    if (from_cmp) cmp_pin <= lvl;
    else cap_pin <= lvl;
    for (n = 1; n < 20; n++) begin
      @(posedge clk_sys_i);
      #1;
      if (cap_flag === 1'b1) break;
    end
  endtask : edge_on
  task automatic clear_flag(input logic by_vec);
    @(posedge clk_sys_i);
    if (by_vec) vec_ack <= 1'b1;
    else flag_clr <= 1'b1;
    @(posedge clk_sys_i);
    vec_ack <= 1'b0;
    flag_clr <= 1'b0;
    #1;
  endtask : clear_flag
  // Count match pulses and the highest low byte over a window
  task automatic watch(input int len, output int m, output logic [7:0] peak);
    m = 0;
    peak = 8'h00;
    repeat (len) begin
      cyc(1);
      if (match === 1'b1) m++;
      if (cnt[7:0] > peak) peak = cnt[7:0];
    end
  endtask : watch
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int n0, n1, m;
    logic [7:0] v, pk;
    logic [15:0] r;
    int divs[6];
    divs = '{0, 1, 8, 64, 256, 1024};
    repeat (5) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    // Reset values, read-only bits and an unmapped place
    rchk(CTRL_A_ADDR, CTRL_A_RESET);
    rchk(CTRL_B_ADDR, CTRL_B_RESET);
    cpu_u.wr(CTRL_A_ADDR, 8'h06);
    rchk(CTRL_A_ADDR, 8'h00);
    cpu_u.wr(6'h3f, 8'h5a);
    rchk(6'h3f, 8'h00);
    cpu_u.wr(CNT_LOW_ADDR, 8'ha5);
    check(cnt, 16'h00a5);
    // Paired 16-bit access with random values, counter stopped meanwhile
    cpu_u.wr(CTRL_A_ADDR, 8'h80);
    for (int i = 0; i < 6; i++) begin
      r = 16'(rnd() >> 8);
      cpu_u.wr16(r);
      check(cnt, r);
      // A lone high write only spoils the latch, so the low read must refill it
      cpu_u.wr(CNT_HIGH_ADDR, ~r[15:8]);
      check(cnt, r);
      cpu_u.rd(CNT_LOW_ADDR, v);
      check({8'h00, v}, {8'h00, r[7:0]});
      check({8'h00, temp}, {8'h00, r[15:8]});
      rchk(CNT_HIGH_ADDR, r[15:8]);
      cpu_u.wr(CNT_LOW_ADDR, 8'h3c);
      check(cnt, {r[15:8], 8'h3c});
    end
    // Stop holds the count; every internal rate: four ticks per four periods whatever the phase
    cpu_u.wr(CTRL_A_ADDR, 8'h00);
    for (int c = 0; c < 6; c++) begin
      cpu_u.wr(CTRL_B_ADDR, 8'(c));
      r = cnt;
      cyc(c == 0 ? 64 : 4 * divs[c]);
      check({8'h00, cnt[7:0] - r[7:0]}, (c == 0) ? 16'h0000 : 16'h0004);
    end
    // Sync hold keeps the prescaler in reset; leaving it clears a written one
    cpu_u.wr(CTRL_B_ADDR, 8'h19);
    r = cnt;
    cyc(20);
    check(cnt, r);
    rchk(CTRL_B_ADDR, 8'h19);
    cpu_u.wr(CTRL_B_ADDR, 8'h09);
    rchk(CTRL_B_ADDR, 8'h01);
    r = cnt;
    cyc(4);
    check({8'h00, cnt[7:0] - r[7:0]}, 16'h0004);
    cpu_u.wr(CTRL_B_ADDR, 8'h09);
    rchk(CTRL_B_ADDR, 8'h01);
    // Low-byte write lands on the compare value: that match is swallowed
    @(posedge clk_sys_i);
    cmp_val <= {8'(rnd() >> 24), 8'h40};
    cpu_u.wr(CNT_LOW_ADDR, 8'h30);
    cpu_u.wr(CNT_LOW_ADDR, 8'h40);
    watch(4, m, pk);
    check(16'(m), 16'h0000);
    // Clear-on-match gives a period of compare plus one; normal wraps at 256
    cpu_u.wr(CTRL_A_ADDR, 8'h01);
    for (n0 = 0; n0 < 300 && match !== 1'b1; n0++) cyc(1);
    check(16'(n0 < 300), 16'h0001);
    watch(130, m, pk);
    check(16'(m), 16'h0002);
    check({8'h00, pk}, 16'h0040);
    cpu_u.wr(CTRL_A_ADDR, 8'h00);
    watch(256, m, pk);
    check(16'(m), 16'h0001);
    check({8'h00, pk}, 16'h00ff);
    // External pin, falling then rising: five of ten transitions count
    for (int c = 6; c < 8; c++) begin
      cpu_u.wr(CTRL_B_ADDR, 8'(c));
      r = cnt;
      repeat (10) begin
        @(posedge clk_sys_i);
        ext_pin <= ~ext_pin;
        cyc(6);
      end
      check({8'h00, cnt[7:0] - r[7:0]}, 16'h0005);
    end
    // Capture with stopped counter: edge choice, copy, both clear paths
    cpu_u.wr(CTRL_B_ADDR, 8'h00);
    cpu_u.wr(CNT_LOW_ADDR, 8'h77);
    cpu_u.wr(CTRL_A_ADDR, 8'h50);
    edge_on(1'b0, 1'b1, n0);
    check(16'(cap_flag), 16'h0001);
    check(cap_val, 16'h0077);
    check(16'(n0), 16'h0003);
    clear_flag(1'b1);
    check(16'(cap_flag), 16'h0000);
    edge_on(1'b0, 1'b0, n1);
    check(16'(cap_flag), 16'h0000);
    cpu_u.wr(CTRL_A_ADDR, 8'h40);
    edge_on(1'b0, 1'b1, n1);
    check(16'(cap_flag), 16'h0000);
    edge_on(1'b0, 1'b0, n1);
    check(16'(cap_flag), 16'h0001);
    clear_flag(1'b0);
    check(16'(cap_flag), 16'h0000);
    // Filter adds four cycles and rejects a two-cycle glitch
    cpu_u.wr(CTRL_A_ADDR, 8'h70);
    edge_on(1'b0, 1'b1, n1);
    check(16'(n1 - n0), 16'h0004);
    clear_flag(1'b0);
    @(posedge clk_sys_i);
    cap_pin <= 1'b0;
    @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    cap_pin <= 1'b1;
    cyc(12);
    check(16'(cap_flag), 16'h0000);
    // Comparator as source; the mask bit outside is left to software
    cpu_u.wr(CTRL_A_ADDR, 8'h58);
    edge_on(1'b0, 1'b0, n1);
    edge_on(1'b0, 1'b1, n1);
    check(16'(cap_flag), 16'h0000);
    edge_on(1'b1, 1'b1, n1);
    check(16'(cap_flag), 16'h0001);
    clear_flag(1'b0);
    cpu_u.wr(CTRL_A_ADDR, 8'h50);
    edge_on(1'b1, 1'b0, n1);
    edge_on(1'b1, 1'b1, n1);
    check(16'(cap_flag), 16'h0000);
    // Capture mode off: edges are ignored
    cpu_u.wr(CTRL_A_ADDR, 8'h10);
    edge_on(1'b0, 1'b0, n1);
    edge_on(1'b0, 1'b1, n1);
    check(16'(cap_flag), 16'h0000);
    tally_and_finish();
  end
endmodule : tb_timer0_capture_prescale_ctrl
`default_nettype wire
